//--- hw/programmable_crc_control.sv
// Purpose: control, status and avalon-mm slave of the programmable crc block
// Assumes: idle_mode comes from same-clock power logic
// Notes: one wait state per access
// Overview of operation
// - idle_stop set halts crc during idle
// - word count readable at bits 12:8
// - depth 8 if length field above 7 (length above 8), else 16
// - full flag bit 7 at depth limit
// - empty flag bit 6, resets to one
// - run bit 4 starts/stops serial shifter
// - length field bits 3:0, length minus one
// - bits 15, 14, 5 read zero
`timescale 1ns/1ps
`include "crc_defs.svh"
module programmable_crc_control #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire crc_pkg::bus_addr_t address,
  input wire logic read,
  input wire logic write,
  input wire crc_pkg::bus_word_t writedata,
  input wire logic [3:0] byteenable,
  output crc_pkg::bus_word_t readdata,
  output logic waitrequest,
  input wire logic idle_mode,
  output logic irq
);
  import crc_pkg::*;

  logic ack_ff, nxt_ack;
  bus_word_t rdata_ff, nxt_rdata;
  logic idle_stop_ff, nxt_idle_stop;
  logic run_ff, nxt_run;
  logic [3:0] poly_length_field_ff, nxt_poly_length_field;
  crc_word_t poly_ff, nxt_poly;
  logic [1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask, events;
  logic req, wr, halted, shift_en;
  logic [4:0] count, limit;
  logic full, empty, push, pop, overflow, done;
  logic busy, last, seed_load;
  crc_word_t head, crc;
  logic [15:0] ctrl_view;

  assign req = read | write;
  assign waitrequest = req & ~ack_ff;
  assign wr = write & ack_ff;

  assign limit = (poly_length_field_ff > `CRC_POLY_LENGTH_FIELD_DEEP_MAX) ? `CRC_DEPTH_SHALLOW : `CRC_DEPTH_DEEP;
  assign full = (count >= limit);
  assign empty = (count == 5'h00);

  assign halted = idle_stop_ff & idle_mode;
  assign shift_en = run_ff & ~halted;
  assign pop = shift_en & ~busy & ~empty;

  // writes at the limit are dropped and flagged
  assign push = wr & (address == `CRC_OFS_DATA) & (|byteenable[1:0]) & ~full;
  assign overflow = wr & (address == `CRC_OFS_DATA) & (|byteenable[1:0]) & full;
  assign seed_load = wr & (address == `CRC_OFS_RESULT) & (|byteenable[1:0]) & ~busy;
  assign done = last & empty & ~push;

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[`CRC_CTRL_IDLE_STOP] = idle_stop_ff;
    ctrl_view[`CRC_CTRL_COUNT_LSB +: 5] = count;
    ctrl_view[`CRC_CTRL_FULL] = full;
    ctrl_view[`CRC_CTRL_EMPTY] = empty;
    ctrl_view[`CRC_CTRL_RUN] = run_ff;
    ctrl_view[`CRC_CTRL_POLY_LENGTH_FIELD_LSB +: 4] = poly_length_field_ff;
  end

  // bus access: read data captured on the stall cycle
  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (read && !ack_ff) begin
      unique case (address)
        `CRC_OFS_CTRL: nxt_rdata = {16'h0000, ctrl_view};
        `CRC_OFS_POLY: nxt_rdata = {16'h0000, poly_ff};
        `CRC_OFS_RESULT: nxt_rdata = {16'h0000, crc};
        `CRC_OFS_IRQ_STAT: nxt_rdata = {30'h0, irq_stat_ff};
        `CRC_OFS_IRQ_MASK: nxt_rdata = {30'h0, irq_mask_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // control registers; bits 15, 14 and 5 have no storage
  always_comb begin
    nxt_idle_stop = idle_stop_ff;
    nxt_run = run_ff;
    nxt_poly_length_field = poly_length_field_ff;
    nxt_poly = poly_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr && address == `CRC_OFS_CTRL) begin
      if (byteenable[1]) begin
        nxt_idle_stop = writedata[`CRC_CTRL_IDLE_STOP];
      end
      if (byteenable[0]) begin
        nxt_run = writedata[`CRC_CTRL_RUN];
        nxt_poly_length_field = writedata[`CRC_CTRL_POLY_LENGTH_FIELD_LSB +: 4];
      end
    end
    if (wr && address == `CRC_OFS_POLY) begin
      if (byteenable[0]) begin
        nxt_poly[7:0] = writedata[7:0];
      end
      if (byteenable[1]) begin
        nxt_poly[15:8] = writedata[15:8];
      end
    end
    if (wr && address == `CRC_OFS_IRQ_MASK && byteenable[0]) begin
      nxt_irq_mask = writedata[1:0];
    end
  end

  // sticky events: set wins over write-one-to-clear
  always_comb begin
    events = 2'b00;
    events[`CRC_IRQ_DONE] = done;
    events[`CRC_IRQ_OVERFLOW] = overflow;
    nxt_irq_stat = irq_stat_ff;
    if (wr && address == `CRC_OFS_IRQ_STAT && byteenable[0]) begin
      nxt_irq_stat = irq_stat_ff & ~writedata[1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idle_stop_ff <= 1'b0;
      run_ff <= 1'b0;
      poly_length_field_ff <= `CRC_RST_POLY_LENGTH_FIELD;
      poly_ff <= `CRC_RST_POLY;
      irq_stat_ff <= `CRC_RST_IRQ;
      irq_mask_ff <= `CRC_RST_IRQ;
    end else begin
      idle_stop_ff <= nxt_idle_stop;
      run_ff <= nxt_run;
      poly_length_field_ff <= nxt_poly_length_field;
      poly_ff <= nxt_poly;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);
  assign readdata = rdata_ff;

  crc_fifo #(
    .WIDTH(`CRC_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .push(push),
    .push_data(writedata[15:0]),
    .pop(pop),
    .pop_data(head),
    .count(count)
  );

  crc_shifter u_shifter (
    .clk(clk),
    .srst(srst),
    .enable(shift_en),
    .start(pop),
    .word(head),
    .poly_length_field(poly_length_field_ff),
    .poly(poly_ff),
    .seed_load(seed_load),
    .seed(writedata[15:0]),
    .busy(busy),
    .last(last),
    .crc(crc)
  );
endmodule // programmable_crc_control

//--- hw/crc_defs.svh
// Purpose: register map, field positions, reset values and counts of the crc block
// Assumes: byte addresses on a 32-bit avalon-mm slave, one register per word
// Notes: definitions only
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

`define CRC_OFS_CTRL 8'h00
`define CRC_OFS_POLY 8'h04
`define CRC_OFS_DATA 8'h08
`define CRC_OFS_RESULT 8'h0C
`define CRC_OFS_IRQ_STAT 8'h10
`define CRC_OFS_IRQ_MASK 8'h14

`define CRC_CTRL_IDLE_STOP 13
`define CRC_CTRL_COUNT_LSB 8
`define CRC_CTRL_FULL 7
`define CRC_CTRL_EMPTY 6
`define CRC_CTRL_RUN 4
`define CRC_CTRL_POLY_LENGTH_FIELD_LSB 0

`define CRC_IRQ_DONE 0
`define CRC_IRQ_OVERFLOW 1

`define CRC_RST_POLY_LENGTH_FIELD 4'h0
`define CRC_RST_POLY 16'h0000
`define CRC_RST_RESULT 16'h0000
`define CRC_RST_IRQ 2'h0

`define CRC_POLY_LENGTH_FIELD_DEEP_MAX 4'h7
`define CRC_DEPTH_SHALLOW 5'h08
`define CRC_DEPTH_DEEP 5'h10
`define CRC_WORD_BITS 16
`define CRC_LAST_BIT 4'hF

`endif

//--- hw/crc_pkg.sv
// Purpose: shared types of the crc block
// Assumes: nothing beyond crc_defs.svh
// Notes: fsm states and bus-facing widths
package crc_pkg;
  typedef enum logic {
    SH_IDLE,
    SH_SHIFT
  } shift_state_e;
  typedef logic [31:0] bus_word_t;
  typedef logic [7:0] bus_addr_t;
  typedef logic [15:0] crc_word_t;
endpackage

//--- hw/crc_fifo.sv
// Purpose: input word fifo with a depth limit chosen at run time
// Assumes: caller never pushes at the limit nor pops when empty
// Notes: flip-flop storage, index-addressed
`timescale 1ns/1ps
`include "crc_defs.svh"
module crc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic [4:0] count
);
  import crc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [4:0] count_ff, nxt_count;

  always_comb begin
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 5'h01;
    end else if (pop && !push) begin
      nxt_count = count_ff - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= 5'h00;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end

  // storage entries carry no reset; the count marks what is valid
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk) begin
        if (push && wr_ptr_ff == AW'(gi)) begin
          mem_ff[gi] <= push_data;
        end
      end
    end
  endgenerate

  assign pop_data = mem_ff[rd_ptr_ff];
  assign count = count_ff;
endmodule // crc_fifo

//--- hw/crc_shifter.sv
// Purpose: serial crc shifter, one data bit per clock, msb first
// Assumes: start only while idle; seed_load only while idle
// Notes: enable low freezes a word in progress; seed_load and start still act while idle
`timescale 1ns/1ps
`include "crc_defs.svh"
module crc_shifter (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic start,
  input wire crc_pkg::crc_word_t word,
  input wire logic [3:0] poly_length_field,
  input wire crc_pkg::crc_word_t poly,
  input wire logic seed_load,
  input wire crc_pkg::crc_word_t seed,
  output logic busy,
  output logic last,
  output crc_pkg::crc_word_t crc
);
  import crc_pkg::*;
  shift_state_e state_ff, nxt_state;
  crc_word_t crc_ff, nxt_crc, data_ff, nxt_data, len_mask;
  logic [3:0] bit_ff, nxt_bit;
  logic fb;

  always_comb begin
    len_mask = 16'hFFFF >> (4'hF - poly_length_field);
    fb = crc_ff[poly_length_field] ^ data_ff[`CRC_WORD_BITS-1];
    nxt_state = state_ff;
    nxt_crc = crc_ff;
    nxt_data = data_ff;
    nxt_bit = bit_ff;
    last = 1'b0;
    unique case (state_ff)
      SH_IDLE: begin
        if (seed_load) begin
          nxt_crc = seed & len_mask;
        end
        if (start) begin
          nxt_state = SH_SHIFT;
          nxt_data = word;
          nxt_bit = 4'h0;
        end
      end
      SH_SHIFT: begin
        if (enable) begin
          nxt_crc = ((crc_ff << 1) ^ (fb ? poly : 16'h0000)) & len_mask;
          nxt_data = data_ff << 1;
          nxt_bit = bit_ff + 4'h1;
          if (bit_ff == `CRC_LAST_BIT) begin
            nxt_state = SH_IDLE;
            last = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= SH_IDLE;
      crc_ff <= `CRC_RST_RESULT;
      data_ff <= 16'h0000;
      bit_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      crc_ff <= nxt_crc;
      data_ff <= nxt_data;
      bit_ff <= nxt_bit;
    end
  end

  assign busy = (state_ff == SH_SHIFT);
  assign crc = crc_ff;
endmodule // crc_shifter

//--- testbench/crc_ctrl_checker.sv
// Purpose: port-level checks of the crc control block
// Assumes: one wait state per access; control bits follow bus writes
// Notes: control fields modelled from accepted writes
`timescale 1ns/1ps
`include "crc_defs.svh"
module crc_ctrl_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire crc_pkg::bus_addr_t address,
  input wire logic read,
  input wire logic write,
  input wire crc_pkg::bus_word_t writedata,
  input wire logic [3:0] byteenable,
  input wire crc_pkg::bus_word_t readdata,
  input wire logic waitrequest,
  input wire logic idle_mode,
  input wire logic irq
);
  import crc_pkg::*;
  logic [5:0] ctl_ff;
  logic [5:0] nxt_ctl;
  logic rc;
  logic wc;
  logic req;
  assign req = read || write;
  assign rc = read && !waitrequest && address == `CRC_OFS_CTRL;
  assign wc = write && !waitrequest && address == `CRC_OFS_CTRL;
  always_comb begin
    nxt_ctl = ctl_ff;
    if (wc && byteenable[0]) begin
      nxt_ctl[4:0] = writedata[4:0];
    end
    if (wc && byteenable[1]) begin
      nxt_ctl[5] = writedata[13];
    end
    if (srst) begin
      nxt_ctl = 6'h00;
    end
  end
  always_ff @(posedge clk) begin
    ctl_ff <= nxt_ctl;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rsv; rc |-> readdata[31:14] == 18'h0 && !readdata[5]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits set");
  property p_empty; rc |-> readdata[6] == (readdata[12:8] == 5'h00); endproperty
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  property p_full;
    rc |-> readdata[7] == (readdata[12:8] >= (readdata[3:0] > 4'h7 ? 5'h08 : 5'h10));
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong");
  property p_depth; rc |-> readdata[12:8] <= FIFO_DEPTH; endproperty
  a_depth: assert property (p_depth) else $error("word count above depth");
  property p_poly_length_field; rc |-> readdata[3:0] == ctl_ff[3:0]; endproperty
  a_poly_length_field: assert property (p_poly_length_field) else $error("length field readback wrong");
  property p_run; rc |-> readdata[4] == ctl_ff[4]; endproperty
  a_run: assert property (p_run) else $error("run bit readback wrong");
  property p_idle; rc |-> readdata[13] == ctl_ff[5]; endproperty
  a_idle: assert property (p_idle) else $error("idle stop readback wrong");
  property p_stall; req && !$past(req) |-> waitrequest ##1 !waitrequest; endproperty
  a_stall: assert property (p_stall) else $error("wait state count wrong");
  c_full: cover property (rc && readdata[7]);
  c_irq: cover property (irq);
  c_halt: cover property (rc && readdata[13] && readdata[4] && idle_mode);
endmodule // crc_ctrl_checker
bind programmable_crc_control crc_ctrl_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .idle_mode(idle_mode), .irq(irq));

//--- testbench/programmable_crc_control_test.sv
// Purpose: self-checking bench of the crc control block
// Assumes: one wait state per access, polynomial 8'h07 with length 8
// Notes: read results compared by a monitor from a queue
`timescale 1ns/1ps
`include "crc_defs.svh"
module programmable_crc_control_test;
  import crc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic idle_mode = 1'b0;
  logic waitrequest;
  logic irq;
  logic [3:0] byteenable = 4'hF;
  bus_addr_t address = 8'h00;
  bus_word_t writedata = 32'h0;
  bus_word_t readdata;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'h9764;
  bus_word_t exp_q[$];
  crc_word_t words[$];
  crc_word_t c;
  programmable_crc_control #(.FIFO_DEPTH(16)) dut (.clk(clk), .srst(srst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .idle_mode(idle_mode), .irq(irq));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input bus_word_t got, input bus_word_t exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr_en, input bus_addr_t a, input bus_word_t d);
    int k;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr_en;
    write <= wr_en;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      cmp({31'h0, waitrequest}, 32'h0);
      end_sim();
    end
  endtask
  task automatic rd(input bus_addr_t a, input bus_word_t e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input bus_addr_t a, input bus_word_t d);
    bus(1'b1, a, d);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask
  task automatic push;
    crc_word_t w;
    w = 16'($random(seed));
    words.push_back(w);
    wr(`CRC_OFS_DATA, {16'h0, w});
  endtask
  // read data taken at the edge where waitrequest is low
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[FAIL] %0t got %0h exp %0h", $time, readdata, 32'h0);
      end else begin
        cmp(readdata, exp_q.pop_front());
      end
    end
  end
  initial begin
    int k;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(`CRC_OFS_CTRL, 32'h0040);
    rd(8'h1C, 32'h0);
    wr(`CRC_OFS_POLY, 32'h0007);
    wr(`CRC_OFS_CTRL, 32'hFFEF);
    rd(`CRC_OFS_CTRL, 32'h204F);
    repeat (8) push();
    rd(`CRC_OFS_CTRL, 32'h288F);
    // deliberate write at the limit: dropped and flagged
    wr(`CRC_OFS_DATA, $random(seed));
    rd(`CRC_OFS_IRQ_STAT, 32'h2);
    chk_irq(1'b0);
    wr(`CRC_OFS_IRQ_MASK, 32'h3);
    chk_irq(1'b1);
    wr(`CRC_OFS_IRQ_STAT, 32'h2);
    chk_irq(1'b0);
    wr(`CRC_OFS_CTRL, 32'h2007);
    rd(`CRC_OFS_CTRL, 32'h2807);
    repeat (8) push();
    rd(`CRC_OFS_CTRL, 32'h3087);
    idle_mode <= 1'b1;
    wr(`CRC_OFS_CTRL, 32'h2017);
    repeat (40) @(posedge clk);
    rd(`CRC_OFS_CTRL, 32'h3097);
    // upper lane only: clears idle stop, keeps run and length
    byteenable <= 4'h2;
    wr(`CRC_OFS_CTRL, 32'h0000);
    byteenable <= 4'hF;
    for (k = 0; k < 1000 && irq !== 1'b1; k++) @(posedge clk);
    if (irq !== 1'b1) begin
      cmp({31'h0, irq}, 32'h1);
      end_sim();
    end
    c = 16'h0;
    foreach (words[i]) begin
      for (int b = 15; b >= 0; b--) begin
        c = ({c[14:0], 1'b0} ^ ((c[7] ^ words[i][b]) ? 16'h0007 : 16'h0000)) & 16'h00FF;
      end
    end
    rd(`CRC_OFS_CTRL, 32'h0057);
    rd(`CRC_OFS_IRQ_STAT, 32'h1);
    rd(`CRC_OFS_RESULT, {16'h0, c});
    wr(`CRC_OFS_IRQ_STAT, 32'h1);
    chk_irq(1'b0);
    // seed write while idle, masked to the 8-bit length
    wr(`CRC_OFS_RESULT, 32'h1234);
    rd(`CRC_OFS_RESULT, 32'h0034);
    // mid-run reset returns every field to its reset value
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(`CRC_OFS_CTRL, 32'h0040);
    rd(`CRC_OFS_RESULT, 32'h0);
    chk_irq(1'b0);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule // programmable_crc_control_test
